// [bench/tb_tape_controller_channel_port.sv]
// Purpose: random and corner traffic through both channel ends
// Assumes: APB answers in access cycle, STAT done polled
// Notes:   expectations computed here, never read back
`include "tcp_defines.svh"
module tb_tape_controller_channel_port
    import tcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr, code;
    logic [31:0] pwdata, prdata, rd, st;
    logic [2:0]  unit_sw;
    logic [10:0] tape_status;
    logic        tape_irq_cond, tape_busy, coded_fmt, rd_frame_valid, rd_block_end;
    logic        swap_sel, wr_frame_valid, func_valid;
    tcp_den_e    density;
    logic [5:0]  rd_frame, wr_frame, fa, fb;
    logic [11:0] func_code, last_func;
    logic [5:0]  wq[$];
    int          miscompares, n_tests;
    tcp_if tcp_if_i ();
    tcp_device tcp_device_i (.pclk(pclk), .presetn(presetn), .chn(tcp_if_i), .unit_sw(unit_sw),
        .tape_status(tape_status), .tape_irq_cond(tape_irq_cond), .tape_busy(tape_busy),
        .coded_fmt(coded_fmt), .density(density), .rd_frame_valid(rd_frame_valid),
        .rd_frame(rd_frame), .rd_block_end(rd_block_end), .swap_sel(swap_sel),
        .wr_frame_valid(wr_frame_valid), .wr_frame(wr_frame), .func_code(func_code),
        .func_valid(func_valid));
    tcp_channel tcp_channel_i (.pclk(pclk), .presetn(presetn), .chn(tcp_if_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    tcp_port_asserts tcp_port_asserts_i (.pclk(pclk), .presetn(presetn),
        .data(tcp_if_i.data), .par(tcp_if_i.par), .dev_data_oe(tcp_if_i.dev_data_oe),
        .connect(tcp_if_i.connect), .func(tcp_if_i.func), .strobe(tcp_if_i.strobe),
        .mclr(tcp_if_i.mclr), .reply(tcp_if_i.reply), .reject(tcp_if_i.reject),
        .record_end_flag(tcp_if_i.record_end_flag));
    // clock generator
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // collect tape frames and accepted function codes
    always @(posedge pclk) begin
        if (wr_frame_valid === 1'b1)
            wq.push_back(wr_frame);
        if (func_valid === 1'b1)
            last_func = func_code;
    end
    // internal to external coded character, unless inhibited
    function automatic logic [31:0] xf(input logic [5:0] f, input logic inh);
        if (inh || f[4] == 1'b0 && f != 6'h00)
            return {26'h0, f};
        return (f == 6'h00) ? 32'h0C : {26'h0, f ^ 6'h20};
    endfunction
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic issue(input logic [2:0] c, input logic [11:0] v);
        density <= tcp_den_e'($urandom_range(2));
        apb(1'b1, `TCP_A_CODE, {20'h0, v});
        apb(1'b1, `TCP_A_CTRL, {29'h0, c});
    endtask
    task automatic wait_done();
        int i = 0;
        do begin
            apb(1'b0, `TCP_A_STAT, 32'h0);
            i++;
        end while (!(rd[8] === 1'b1 && rd[7] === 1'b0) && i < 400);
        if (rd[8] !== 1'b1 || rd[7] !== 1'b0) begin
            miscompares++;
            wrap_up();
        end
        st = rd;
    endtask
    task automatic frame(input logic [5:0] f);
        @(posedge pclk);
        rd_frame_valid <= 1'b1;
        rd_frame       <= f;
        @(posedge pclk);
        rd_frame_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, unit_sw, tape_status} = '0;
        {tape_irq_cond, tape_busy, coded_fmt, rd_frame_valid, rd_frame} = '0;
        {rd_block_end, swap_sel} = '0;
        density = TCP_DEN_HI;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(32'hbf02));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        tape_status <= 11'($urandom);
        swap_sel <= 1'b1;
        tape_busy <= 1'b1;
        unit_sw <= 3'($urandom);
        issue(`TCP_CMD_CONN, 12'($urandom));
        wait_done();
        chk("busy reject", 32'h1, {31'h0, st[9]});
        chk("status", {21'h0, tape_status}, {21'h0, st[22:12]});
        tape_busy <= 1'b0;
        issue(`TCP_CMD_CONN, 12'($urandom));
        wait_done();
        chk("connect", 32'h0, {31'h0, st[9]});
        tape_irq_cond <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("irq", 32'h1 << unit_sw, {24'h0, tcp_if_i.irq_lines});
        for (int k = 0; k < 3; k++) begin
            code = 12'($urandom);
            issue(`TCP_CMD_FUNC, code);
            wait_done();
            chk("func code", {20'h0, code}, {20'h0, last_func});
        end
        coded_fmt <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            code = 12'($urandom);
            wq.delete();
            apb(1'b1, `TCP_A_LINES, {27'h0, 3'h4, m[1], m[0]});
            issue(`TCP_CMD_WR, code);
            wait_done();
            repeat (10) @(posedge pclk);
            chk("frames", m[1] ? 32'h1 : 32'h2, 32'(wq.size()));
            chk("frame hi", xf(code[11:6], m[0]), {26'h0, wq[0]});
            if (m[1] == 1'b0)
                chk("frame lo", xf(code[5:0], m[0]), {26'h0, wq[1]});
        end
        coded_fmt <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            fa = 6'($urandom);
            fb = 6'($urandom);
            apb(1'b1, `TCP_A_LINES, {28'h0, 2'h2, m[0], 1'b0});
            issue(`TCP_CMD_RD, 12'h000);
            repeat (10) @(posedge pclk);
            frame(fa);
            if (m == 0)
                frame(fb);
            wait_done();
            apb(1'b0, `TCP_A_RDATA, 32'h0);
            chk("read word", m ? {26'h0, fa} : {20'h0, fa, fb}, rd);
            chk("swap", 32'h1, {31'h0, tcp_if_i.swap_halves});
        end
        chk("parity fault", 32'h0, {31'h0, st[23]});
        rd_block_end <= 1'b1;
        @(posedge pclk);
        rd_block_end <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("record end", 32'h1, {31'h0, tcp_if_i.record_end_flag});
        repeat (100) @(posedge pclk);
        apb(1'b1, `TCP_A_CTRL, {29'h0, `TCP_CMD_CLR});
        repeat (20) @(posedge pclk);
        issue(`TCP_CMD_FUNC, 12'h001);
        wait_done();
        chk("func after clear", 32'h1, {31'h0, st[9]});
        wrap_up();
    end
endmodule

// [bench/tcp_port_asserts.sv]
// Purpose: concurrent checks on the channel wires
// Assumes: 20 MHz pclk, device answers registered
// Notes:   instantiated beside the interface, no bind
`include "tcp_defines.svh"
module tcp_port_asserts
    import tcp_pkg::*;
(
    input wire logic      pclk,
    input wire logic      presetn,
    input wire tcp_word_t data,
    input wire logic      par,
    input wire logic      dev_data_oe,
    input wire logic      connect,
    input wire logic      func,
    input wire logic      strobe,
    input wire logic      mclr,
    input wire logic      reply,
    input wire logic      reject,
    input wire logic      record_end_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       req;
    logic [8:0] gap;
    logic [8:0] eor_len;
    // any pending channel request
    assign req = connect | func | strobe;
    // cycles since the last reply rose, run length of record end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap     <= 9'h1FF;
            eor_len <= 9'h000;
        end else begin
            if (mclr)
                gap <= 9'h1FF;
            else if ($rose(reply))
                gap <= 9'h000;
            else if (gap != 9'h1FF)
                gap <= gap + 9'h001;
            eor_len <= record_end_flag ? eor_len + 9'h001 : 9'h000;
        end
    end
    one_answer_a: assert property (!(reply && reject))
        else $error("reply and reject high together");
    reply_cause_a: assert property ($rose(reply) |-> req)
        else $error("reply without a request");
    reject_cause_a: assert property ($rose(reject) |-> (connect || func))
        else $error("reject without connect or function");
    reply_hold_a: assert property (reply && req |=> reply)
        else $error("reply dropped while request held");
    answer_drop_a: assert property ($fell(req) |-> ##[1:6] !(reply || reject))
        else $error("answer not dropped after request");
    odd_par_a: assert property (dev_data_oe |-> ^{data, par})
        else $error("device word parity not odd");
    lockout_a: assert property ($rose(reply) |-> gap >= 9'h01D)
        else $error("reply inside lockout");
    eor_len_a: assert property ($fell(record_end_flag) |-> eor_len == 9'h064)
        else $error("record end length wrong");
    mclr_clear_a: assert property (mclr |-> ##[1:8] !(reply || reject || dev_data_oe))
        else $error("clear left answer or data driven");
    cover property ($rose(reply) && connect);
    cover property ($rose(reject));
    cover property ($rose(reply) && strobe);
    cover property ($fell(record_end_flag));
endmodule

// [core/tcp_channel.sv]
// Purpose: data channel end, driven from APB registers
// Assumes: device outputs asynchronous; two-flop synchronised
// Notes:   APB slave answers with pready high in the access cycle
`include "tcp_defines.svh"
module tcp_channel
    import tcp_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    tcp_if.channel            chn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr
);
    // synchronise device answers
    logic [5:0] s1, s2;
    logic [`TCP_ST_W-1:0] st1, st2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {s1, s2, st1, st2} <= '0;
        end else begin
            s1 <= {chn.reply, chn.reject, chn.par_err, chn.record_end_flag,
                   chn.swap_halves, chn.irq_lines != '0};
            s2 <= s1;
            st1 <= chn.status;
            st2 <= st1;
        end
    end
    wire rep_s = s2[5];
    wire rej_s = s2[4];
    wire ans_s = rep_s | rej_s;
    // APB decode
    wire wr_en  = psel & penable & pwrite;
    wire rd_en  = psel & penable & ~pwrite;
    wire hit    = (paddr == `TCP_A_CTRL) | (paddr == `TCP_A_CODE) |
                  (paddr == `TCP_A_WDATA) | (paddr == `TCP_A_STAT) |
                  (paddr == `TCP_A_RDATA) | (paddr == `TCP_A_LINES);
    logic [2:0]  cmd;
    logic        busy, done, rejected, eor_seen, bcd_inh, pack_byp, swap;
    tcp_word_t   code, rdata;
    wire         go = wr_en & (paddr == `TCP_A_CTRL) & ~busy;
    // request sequencer: raise, wait answer, drop, wait answer gone
    typedef enum {TCP_C_IDLE, TCP_C_REQ, TCP_C_REL} tcp_cstate_e;
    tcp_cstate_e cs;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs <= TCP_C_IDLE;
            {busy, done, rejected, eor_seen, bcd_inh, pack_byp, swap} <= '0;
            {cmd, code, rdata} <= '0;
            {chn.connect, chn.func, chn.strobe, chn.rd_dir, chn.wr_dir, chn.mclr} <= '0;
            {chn.ch_data_o, chn.ch_par_o, chn.ch_data_oe, chn.bcd_inh, chn.pack_byp} <= '0;
        end else begin
            chn.mclr <= 1'b0;
            chn.bcd_inh <= bcd_inh;
            chn.pack_byp <= pack_byp;
            if (wr_en && paddr == `TCP_A_CODE) begin
                code <= pwdata[11:0];
            end
            if (wr_en && paddr == `TCP_A_LINES) begin
                {swap, pack_byp, bcd_inh} <= pwdata[2:0];
                chn.rd_dir <= pwdata[3];
                chn.wr_dir <= pwdata[4];
            end
            case (cs)
                TCP_C_IDLE: begin
                    if (go) begin
                        cmd <= pwdata[2:0];
                        done <= 1'b0;
                        rejected <= 1'b0;
                        chn.ch_data_o <= code;
                        chn.ch_par_o <= tcp_par(code);
                        if (pwdata[2:0] == `TCP_CMD_CLR) begin
                            chn.mclr <= 1'b1;
                            chn.rd_dir <= 1'b0;
                            chn.wr_dir <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            busy <= 1'b1;
                            chn.ch_data_oe <= (pwdata[2:0] != `TCP_CMD_RD);
                            chn.connect <= (pwdata[2:0] == `TCP_CMD_CONN);
                            chn.func <= (pwdata[2:0] == `TCP_CMD_FUNC);
                            chn.strobe <= (pwdata[2:0] == `TCP_CMD_RD) |
                                          (pwdata[2:0] == `TCP_CMD_WR);
                            cs <= TCP_C_REQ;
                        end
                    end
                end
                TCP_C_REQ: begin
                    if (ans_s) begin
                        rejected <= rej_s;
                        if (cmd == `TCP_CMD_RD) begin
                            rdata <= chn.data;
                            eor_seen <= s2[2];
                        end
                        chn.connect <= 1'b0;
                        chn.func <= 1'b0;
                        chn.strobe <= 1'b0;
                        chn.ch_data_oe <= 1'b0;
                        cs <= TCP_C_REL;
                    end
                end
                TCP_C_REL: begin
                    if (!ans_s) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        cs <= TCP_C_IDLE;
                    end
                end
                default: cs <= TCP_C_IDLE;
            endcase
        end
    end
    // read mux and APB answer
    wire [31:0] stat_word = {6'h00, s2[0], s2[1], s2[3], st2, eor_seen, s2[2],
                             rejected, done, busy, 7'h00};
    wire [31:0] rd_mux =
        (paddr == `TCP_A_CODE)  ? {20'h00000, code} :
        (paddr == `TCP_A_STAT)  ? stat_word :
        (paddr == `TCP_A_RDATA) ? {20'h00000, rdata} :
        (paddr == `TCP_A_LINES) ? {27'h0000000, chn.wr_dir, chn.rd_dir, swap,
                                   pack_byp, bcd_inh} :
        (paddr == `TCP_A_CTRL)  ? {29'h00000000, cmd} : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
        end
    end
endmodule

// [core/tcp_defines.svh]
// Purpose: constants for the tape controller channel port
// Assumes: 20 MHz pclk (50 ns)
// Notes:   times in ns, cycle counts derived from them
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH
`define TCP_CLK_NS          50
`define TCP_LOCK_HI_NS      1500
`define TCP_LOCK_MID_NS     3500
`define TCP_LOCK_LO_NS      12000
`define TCP_EOR_NS          5000
`define TCP_LOCK_HI_CYC     ((`TCP_LOCK_HI_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_LOCK_MID_CYC    ((`TCP_LOCK_MID_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_LOCK_LO_CYC     ((`TCP_LOCK_LO_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_EOR_CYC         ((`TCP_EOR_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_CNT_W           9
`define TCP_W               12
`define TCP_ST_W            11
`define TCP_NINT            8
// status bit positions
`define TCP_ST_READY        0
`define TCP_ST_BUSY         1
`define TCP_ST_D556         2
`define TCP_ST_FMARK        3
`define TCP_ST_LOADPT       4
`define TCP_ST_EOT          5
`define TCP_ST_WREN         6
`define TCP_ST_D800         7
`define TCP_ST_LOST         8
`define TCP_ST_LPAR         9
`define TCP_ST_VPAR         10
// host register offsets
`define TCP_A_CTRL          12'h000
`define TCP_A_CODE          12'h004
`define TCP_A_WDATA         12'h008
`define TCP_A_STAT          12'h00C
`define TCP_A_RDATA         12'h010
`define TCP_A_LINES         12'h014
// host control command encodings
`define TCP_CMD_CONN        3'h1
`define TCP_CMD_FUNC        3'h2
`define TCP_CMD_RD          3'h3
`define TCP_CMD_WR          3'h4
`define TCP_CMD_CLR         3'h5
`endif

// [core/tcp_device.sv]
// Purpose: tape controller end of the 12-bit data channel
// Assumes: channel pins are asynchronous; two-flop synchronised
// Notes:   tape side is a plain frame port; mclr acts as sync clear
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "tcp_defines.svh"
// Notes on behaviour
// - words carry odd parity over thirteen bits
// - parity fault only while unit connected
// - channel holds read or write level
// - connect request answered Reply or Reject
// - function request answered Reply or Reject
// - master clear zeroes state, drops connection
// - drive swap-halves indication to channel
// - eleven static status lines
// - inhibit level skips code conversion
// - bypass write: one frame, upper six
// - bypass read: upper six bits zero
// - unit-selected interrupt line on condition
// - density-dependent reply lockout after reply
// - record end shaped by 5 us
// - connect honoured: attach, reply held
// - cannot honour: static Reject
// - codes come over data lines
// - strobe held until Reply, then dropped
module tcp_device
    import tcp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    tcp_if.device                      chn,
    input  wire logic [2:0]            unit_sw,
    input  wire logic [`TCP_ST_W-1:0]  tape_status,
    input  wire logic                  tape_irq_cond,
    input  wire logic                  tape_busy,
    input  wire logic                  coded_fmt,
    input  wire tcp_den_e              density,
    input  wire logic                  rd_frame_valid,
    input  wire logic [5:0]            rd_frame,
    input  wire logic                  rd_block_end,
    input  wire logic                  swap_sel,
    output logic                       wr_frame_valid,
    output logic [5:0]                 wr_frame,
    output logic [`TCP_W-1:0]          func_code,
    output logic                       func_valid
);
    // synchronisers for all channel inputs
    logic [20:0] s1, s2;
    wire  [20:0] raw = {chn.data, chn.par, chn.rd_dir, chn.wr_dir, chn.connect,
                        chn.func, chn.strobe, chn.mclr, chn.bcd_inh, chn.pack_byp};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    wire [11:0] d_in   = s2[20:9];
    wire        p_in   = s2[8];
    wire        rd_s   = s2[7];
    wire        wr_s   = s2[6];
    wire        con_s  = s2[5];
    wire        fun_s  = s2[4];
    wire        stb_s  = s2[3];
    wire        mclr_s = s2[2];
    wire        bcd_s2 = s2[1];
    wire        byp_s2 = s2[0];

    // internal/external BCD conversion of one 6-bit character
    function automatic logic [5:0] bcd_i2e(input logic [5:0] c);
        logic [5:0] r;
        r = (c == 6'h00) ? 6'h0C : c;
        return {r[5] ^ r[4], r[4:0]};
    endfunction
    function automatic logic [5:0] bcd_e2i(input logic [5:0] c);
        logic [5:0] r;
        r = {c[5] ^ c[4], c[4:0]};
        return (r == 6'h0C) ? 6'h00 : r;
    endfunction
    wire        conv     = coded_fmt & ~bcd_s2;
    wire [5:0]  rd_chr   = conv ? bcd_e2i(rd_frame) : rd_frame;
    wire        req      = con_s | fun_s | stb_s;
    wire        par_ok   = (tcp_par(d_in) == p_in);
    wire        can_con  = ~tape_busy;

    typedef enum {TCP_IDLE, TCP_ANS, TCP_RD_WAIT, TCP_WR_LO, TCP_LOCK} tcp_state_e;
    tcp_state_e st;
    logic       connected, half, pending;
    logic [5:0] hi_chr;
    wire        can_fun  = connected & ~tape_busy;
    logic [`TCP_CNT_W-1:0] lock_cnt, eor_cnt;
    wire [`TCP_CNT_W-1:0] lock_len =
        (density == TCP_DEN_HI)  ? `TCP_CNT_W'(`TCP_LOCK_HI_CYC) :
        (density == TCP_DEN_MID) ? `TCP_CNT_W'(`TCP_LOCK_MID_CYC) :
                                   `TCP_CNT_W'(`TCP_LOCK_LO_CYC);
    wire [5:0]  wr_hi = conv ? bcd_i2e(d_in[11:6]) : d_in[11:6];
    wire [5:0]  wr_lo = conv ? bcd_i2e(d_in[5:0]) : d_in[5:0];

    // handshake sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= TCP_IDLE;
            {connected, half, pending, hi_chr, lock_cnt, func_code} <= '0;
            {chn.reply, chn.reject, chn.dev_data_o, chn.dev_par_o, chn.dev_data_oe} <= '0;
            {wr_frame_valid, wr_frame, func_valid} <= '0;
        end else if (mclr_s) begin
            st <= TCP_IDLE;
            {connected, half, pending, lock_cnt, wr_frame_valid, func_valid} <= '0;
            {chn.reply, chn.reject, chn.dev_data_oe} <= '0;
        end else begin
            wr_frame_valid <= 1'b0;
            func_valid <= 1'b0;
            // read assembly of tape frames, packed or bypassed
            if (rd_s && rd_frame_valid && !pending) begin
                if (byp_s2) begin
                    chn.dev_data_o <= {6'h00, rd_chr};
                    chn.dev_par_o <= tcp_par({6'h00, rd_chr});
                    pending <= 1'b1;
                end else if (!half) begin
                    hi_chr <= rd_chr;
                    half <= 1'b1;
                end else begin
                    chn.dev_data_o <= {hi_chr, rd_chr};
                    chn.dev_par_o <= tcp_par({hi_chr, rd_chr});
                    half <= 1'b0;
                    pending <= 1'b1;
                end
            end
            case (st)
                TCP_IDLE: begin
                    if (con_s) begin
                        connected <= can_con;
                        chn.reply <= can_con;
                        chn.reject <= ~can_con;
                        st <= TCP_ANS;
                    end else if (fun_s) begin
                        chn.reply <= can_fun;
                        chn.reject <= ~can_fun;
                        func_code <= d_in;
                        func_valid <= can_fun;
                        st <= TCP_ANS;
                    end else if (stb_s && connected && wr_s) begin
                        wr_frame <= wr_hi;
                        wr_frame_valid <= 1'b1;
                        chn.reply <= 1'b1;
                        st <= byp_s2 ? TCP_ANS : TCP_WR_LO;
                    end else if (stb_s && connected && rd_s) begin
                        st <= TCP_RD_WAIT;
                    end
                end
                TCP_WR_LO: begin
                    wr_frame <= wr_lo;
                    wr_frame_valid <= 1'b1;
                    st <= TCP_ANS;
                end
                TCP_RD_WAIT: begin
                    if (!stb_s) begin
                        st <= TCP_IDLE;
                    end else if (pending) begin
                        chn.dev_data_oe <= 1'b1;
                        chn.reply <= 1'b1;
                        pending <= 1'b0;
                        st <= TCP_ANS;
                    end
                end
                TCP_ANS: begin
                    if (!req) begin
                        chn.dev_data_oe <= 1'b0;
                        chn.reject <= 1'b0;
                        if (chn.reply) begin
                            chn.reply <= 1'b0;
                            lock_cnt <= lock_len;
                            st <= TCP_LOCK;
                        end else begin
                            st <= TCP_IDLE;
                        end
                    end
                end
                TCP_LOCK: begin
                    lock_cnt <= lock_cnt - `TCP_CNT_W'(1);
                    if (lock_cnt <= `TCP_CNT_W'(1)) begin
                        st <= TCP_IDLE;
                    end
                end
                default: st <= TCP_IDLE;
            endcase
        end
    end

    // record end pulse, parity fault, status and interrupt outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eor_cnt <= '0;
            {chn.record_end_flag, chn.par_err, chn.swap_halves, chn.status, chn.irq_lines} <= '0;
        end else begin
            if (mclr_s) begin
                eor_cnt <= '0;
            end else if (rd_s && rd_block_end) begin
                eor_cnt <= `TCP_CNT_W'(`TCP_EOR_CYC);
            end else if (eor_cnt != '0) begin
                eor_cnt <= eor_cnt - `TCP_CNT_W'(1);
            end
            chn.record_end_flag <= (eor_cnt != '0) & ~mclr_s;
            chn.par_err <= connected & ~mclr_s & (req & wr_s | con_s | fun_s) & ~par_ok;
            chn.swap_halves <= swap_sel & rd_s;
            chn.status <= tape_status;
            chn.irq_lines <= (connected & tape_irq_cond & ~mclr_s)
                             ? `TCP_NINT'(1) << unit_sw : '0;
        end
    end
endmodule

// [core/tcp_if.sv]
// Purpose: channel wires between tape controller and data channel
// Assumes: data lines resolved from the two enables
// Notes:   no clocking block
`include "tcp_defines.svh"
interface tcp_if;
    import tcp_pkg::*;
    tcp_word_t           dev_data_o;
    logic                dev_par_o;
    logic                dev_data_oe;
    tcp_word_t           ch_data_o;
    logic                ch_par_o;
    logic                ch_data_oe;
    tcp_word_t           data;
    logic                par;
    logic                rd_dir;
    logic                wr_dir;
    logic                connect;
    logic                func;
    logic                strobe;
    logic                mclr;
    logic                bcd_inh;
    logic                pack_byp;
    logic                reply;
    logic                reject;
    logic                par_err;
    logic                record_end_flag;
    logic                swap_halves;
    logic [`TCP_ST_W-1:0] status;
    logic [`TCP_NINT-1:0] irq_lines;
    // wired bus level from the enables
    assign data = dev_data_oe ? dev_data_o : (ch_data_oe ? ch_data_o : '0);
    assign par  = dev_data_oe ? dev_par_o  : (ch_data_oe ? ch_par_o  : 1'b0);
    modport device (
        input  data, par, rd_dir, wr_dir, connect, func, strobe, mclr, bcd_inh, pack_byp,
        output dev_data_o, dev_par_o, dev_data_oe, reply, reject, par_err,
               record_end_flag, swap_halves, status, irq_lines
    );
    modport channel (
        input  data, par, dev_data_oe, reply, reject, par_err, record_end_flag,
               swap_halves, status, irq_lines,
        output ch_data_o, ch_par_o, ch_data_oe, rd_dir, wr_dir, connect, func, strobe,
               mclr, bcd_inh, pack_byp
    );
endinterface

// [core/tcp_pkg.sv]
// Purpose: types for the tape controller channel port
// Assumes: tcp_defines.svh supplies constants
// Notes:   parity helper shared by both ends
`include "tcp_defines.svh"
package tcp_pkg;
    typedef logic [`TCP_W-1:0] tcp_word_t;
    typedef enum logic [1:0] {TCP_DEN_LO, TCP_DEN_MID, TCP_DEN_HI} tcp_den_e;
    // odd parity bit for a 12-bit word
    function automatic logic tcp_par(input tcp_word_t w);
        return ~(^w);
    endfunction
endpackage
